// file: hdl/swc_map.vh
`ifndef SWC_MAP_VH
`define SWC_MAP_VH
// Register offsets
`define SWC_REG_CTRL      4'h0
`define SWC_REG_STATUS    4'h1
`define SWC_REG_IRQEN     4'h2
`define SWC_REG_WAKE      4'h3
// Control register fields
`define SWC_CTRL_WDT_SLP  0
`define SWC_CTRL_WDT_EN   1
`define SWC_CTRL_GIE      2
`define SWC_CTRL_MASTER_CLEAR_PIN_EN  3
`define SWC_CTRL_BOR_EN   4
`define SWC_CTRL_ADC_RC   5
`define SWC_CTRL_T1_EXT   6
`define SWC_CTRL_RST      8'h00
// Status register fields
`define SWC_ST_PD         0
`define SWC_ST_TO         1
`define SWC_ST_ASLEEP     2
`define SWC_STATUS_RST    8'h03
// Wake cause codes
`define SWC_CAUSE_NONE    3'h0
`define SWC_CAUSE_WDT     3'h1
`define SWC_CAUSE_IRQ     3'h2
`define SWC_CAUSE_RST     3'h3
// Watchdog timeout count
`define SWC_WDT_LIMIT     16'hFFFF
`endif

// file: hdl/swc_sync.v
`timescale 1ns/1ps
// Three-stage input synchroniser; output moves once stages two and three agree
module swc_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clk_in,
    input  wire             rst_in,
    input  wire             ce_in,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q     <= {WIDTH{1'b0}};
            s2_q     <= {WIDTH{1'b0}};
            s3_q     <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else if (ce_in) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            sync_out <= (s2_q & s3_q) | (sync_out & (s2_q | s3_q));
        end
    end
endmodule // swc_sync

// file: hdl/swc_wdt.v
`timescale 1ns/1ps
`include "swc_map.vh"
// Watchdog counter with synchronous clear
module swc_wdt #(
    parameter [15:0] LIMIT = `SWC_WDT_LIMIT
) (
    // Clock and reset
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire        ce_in,
    // Control
    input  wire        run_in,
    input  wire        clear_in,
    // Status
    output reg  [15:0] count_out,
    output reg         timeout_out
);
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_out   <= 16'h0000;
            timeout_out <= 1'b0;
        end else if (ce_in) begin
            timeout_out <= 1'b0;
            if (clear_in) begin
                count_out <= 16'h0000;
            end else if (run_in) begin
                if (count_out == LIMIT) begin
                    count_out   <= 16'h0000;
                    timeout_out <= 1'b1;
                end else begin
                    count_out <= count_out + 16'h0001;
                end
            end
        end
    end
endmodule // swc_wdt

// file: hdl/swc_ctrl.v
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "swc_map.vh"
// Functional notes
// - Sleep instruction from the core puts the device into power-down.
// - Watchdog cleared on sleep entry; keeps counting if enabled for sleep.
// - Sleep entry clears the power-down flag.
// - Sleep entry sets the timeout flag.
// - Processor core clock gated off throughout sleep.
// - Low-frequency oscillator and its peripherals keep running in sleep.
// - Second timer runs in sleep when clocked from pin, crystal or sense osc.
// - Converter keeps running in sleep on its dedicated RC oscillator.
// - Capacitive-sensing oscillator runs unaffected in sleep.
// - Port drive states held frozen during sleep.
// - Sleep leaves all reset sources except the watchdog unchanged.
// - Wake on pin reset, brown-out, power-on, watchdog or enabled interrupts.
// - Reset-type wakes reset the device; watchdog and interrupt wakes continue.
// - Next instruction is prefetched while sleep executes.
// - Interrupt wakes only when its own enable bit is set.
// - Wake happens regardless of global interrupt enable.
// - With global enable set, run next instruction then branch to handler.
// - Watchdog cleared on every wake from sleep.
module swc_ctrl #(
    parameter        NIRQ  = 8,
    parameter        NPORT = 8,
    parameter [15:0] WDT_LIMIT = `SWC_WDT_LIMIT
) (
    // Clock, reset, enable
    input  wire             clk_in,
    input  wire             rst_in,
    input  wire             ce_in,
    // Register port
    input  wire [3:0]       addr_in,
    input  wire [7:0]       wdata_in,
    input  wire             wr_in,
    input  wire             rd_in,
    output reg  [7:0]       rdata_out,
    // Processor core
    input  wire             sleep_exec_in,
    input  wire             clrwdt_in,
    output reg              core_clk_en_out,
    output reg              prefetch_out,
    output reg              resume_out,
    output reg              isr_call_out,
    // Reset sources, from pins
    input  wire             master_clear_pin_pin_in,
    input  wire             bor_in,
    input  wire             por_in,
    output reg              dev_reset_out,
    output reg              wdt_reset_out,
    // Interrupt sources
    input  wire [NIRQ-1:0]  irq_flag_in,
    // Clock domains that stay alive
    output reg              lfosc_en_out,
    output reg              t1_clk_en_out,
    output reg              adc_clk_en_out,
    output reg              sense_osc_en_out,
    // Ports
    input  wire [NPORT-1:0] port_drv_in,
    input  wire [NPORT-1:0] port_oe_in,
    output reg  [NPORT-1:0] port_drv_out,
    output reg  [NPORT-1:0] port_oe_out,
    // State
    output reg              asleep_out
);
    ////////////////////////////////////////////////////////////////////////////
    localparam [2:0] ST_RUN   = 3'b001;
    localparam [2:0] ST_SLEEP = 3'b010;
    localparam [2:0] ST_WAKE  = 3'b100;

    reg  [2:0]       state_q;
    reg  [7:0]       ctrl_q;
    reg  [7:0]       irqen_q;
    reg              pd_q;
    reg              to_q;
    reg  [2:0]       cause_q;
    wire [2:0]       rst_sync;
    wire [15:0]      wdt_count;
    wire             wdt_timeout;
    wire             master_clear_pin_rst;
    wire             bor_rst;
    wire             any_rst;
    wire             irq_wake;
    wire             sleep_go;
    wire             wdt_clear;
    wire             wdt_run;
    wire [NIRQ-1:0]  irq_hit;

    ////////////////////////////////////////////////////////////////////////////
    swc_sync #(
        .WIDTH   (3)
    ) u_sync (
        .clk_in  (clk_in),
        .rst_in  (rst_in),
        .ce_in   (ce_in),
        .async_in({por_in, bor_in, master_clear_pin_pin_in}),
        .sync_out(rst_sync)
    );

    // Reset sources behave identically awake or asleep
    assign master_clear_pin_rst = rst_sync[0] & ctrl_q[`SWC_CTRL_MASTER_CLEAR_PIN_EN];
    assign bor_rst  = rst_sync[1] & ctrl_q[`SWC_CTRL_BOR_EN];
    assign any_rst  = master_clear_pin_rst | bor_rst | rst_sync[2];

    // Per-source enable only; global enable deliberately not consulted
    genvar gi;
    generate
        for (gi = 0; gi < NIRQ; gi = gi + 1) begin : g_irq
            assign irq_hit[gi] = irq_flag_in[gi] & irqen_q[gi];
        end
    endgenerate
    assign irq_wake = |irq_hit;

    assign sleep_go  = (state_q == ST_RUN) & sleep_exec_in & ~any_rst;
    // Clear on entry and on every wake
    assign wdt_clear = clrwdt_in | sleep_go |
                       ((state_q == ST_SLEEP) &
                        (any_rst | irq_wake | wdt_timeout));
    assign wdt_run   = ctrl_q[`SWC_CTRL_WDT_EN] &
                       ((state_q != ST_SLEEP) | ctrl_q[`SWC_CTRL_WDT_SLP]);

    swc_wdt #(
        .LIMIT      (WDT_LIMIT)
    ) u_wdt (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .run_in     (wdt_run),
        .clear_in   (wdt_clear),
        .count_out  (wdt_count),
        .timeout_out(wdt_timeout)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q         <= ST_RUN;
            pd_q            <= 1'b1;
            to_q            <= 1'b1;
            cause_q         <= `SWC_CAUSE_NONE;
            core_clk_en_out <= 1'b1;
            prefetch_out    <= 1'b0;
            resume_out      <= 1'b0;
            isr_call_out    <= 1'b0;
            dev_reset_out   <= 1'b0;
            wdt_reset_out   <= 1'b0;
            asleep_out      <= 1'b0;
        end else if (ce_in) begin
            prefetch_out  <= 1'b0;
            resume_out    <= 1'b0;
            isr_call_out  <= 1'b0;
            dev_reset_out <= 1'b0;
            wdt_reset_out <= 1'b0;
            case (state_q)
                ST_RUN: begin
                    if (any_rst) begin
                        dev_reset_out <= 1'b1;
                        cause_q       <= `SWC_CAUSE_RST;
                    end else if (wdt_timeout) begin
                        // Awake timeout is a watchdog reset
                        wdt_reset_out <= 1'b1;
                        to_q          <= 1'b0;
                        cause_q       <= `SWC_CAUSE_WDT;
                    end else if (sleep_go) begin
                        state_q         <= ST_SLEEP;
                        pd_q            <= 1'b0;
                        to_q            <= 1'b1;
                        prefetch_out    <= 1'b1;
                        core_clk_en_out <= 1'b0;
                        asleep_out      <= 1'b1;
                    end else if (clrwdt_in) begin
                        pd_q <= 1'b1;
                        to_q <= 1'b1;
                    end
                end
                ST_SLEEP: begin
                    if (any_rst) begin
                        // Full device reset, core clock restored for it
                        state_q         <= ST_RUN;
                        dev_reset_out   <= 1'b1;
                        cause_q         <= `SWC_CAUSE_RST;
                        core_clk_en_out <= 1'b1;
                        asleep_out      <= 1'b0;
                    end else if (wdt_timeout | irq_wake) begin
                        state_q         <= ST_WAKE;
                        core_clk_en_out <= 1'b1;
                        asleep_out      <= 1'b0;
                        if (wdt_timeout) begin
                            to_q    <= 1'b0;
                            cause_q <= `SWC_CAUSE_WDT;
                        end else begin
                            cause_q <= `SWC_CAUSE_IRQ;
                        end
                    end
                end
                ST_WAKE: begin
                    // Clock is already running; now release the prefetched word
                    state_q    <= ST_RUN;
                    resume_out <= 1'b1;
                    isr_call_out <= (cause_q == `SWC_CAUSE_IRQ) &
                                    ctrl_q[`SWC_CTRL_GIE];
                end
                default: begin
                    state_q         <= ST_RUN;
                    core_clk_en_out <= 1'b1;
                    asleep_out      <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Domains that survive sleep and frozen port state
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lfosc_en_out     <= 1'b1;
            t1_clk_en_out    <= 1'b1;
            adc_clk_en_out   <= 1'b1;
            sense_osc_en_out <= 1'b1;
            port_drv_out     <= {NPORT{1'b0}};
            port_oe_out      <= {NPORT{1'b0}};
        end else if (ce_in) begin
            lfosc_en_out     <= 1'b1;
            sense_osc_en_out <= 1'b1;
            t1_clk_en_out    <= ~asleep_out | ctrl_q[`SWC_CTRL_T1_EXT];
            adc_clk_en_out   <= ~asleep_out | ctrl_q[`SWC_CTRL_ADC_RC];
            // Ports follow the core only while awake
            if (!asleep_out && !sleep_go) begin
                port_drv_out <= port_drv_in;
                port_oe_out  <= port_oe_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q    <= `SWC_CTRL_RST;
            irqen_q   <= 8'h00;
            rdata_out <= 8'h00;
        end else if (ce_in) begin
            if (wr_in) begin
                case (addr_in)
                    `SWC_REG_CTRL:  ctrl_q  <= wdata_in;
                    `SWC_REG_IRQEN: irqen_q <= wdata_in;
                    default: begin
                    end
                endcase
            end
            rdata_out <= 8'h00;
            if (rd_in) begin
                case (addr_in)
                    `SWC_REG_CTRL:   rdata_out <= ctrl_q;
                    `SWC_REG_STATUS: rdata_out <= {5'h00, asleep_out, to_q, pd_q};
                    `SWC_REG_IRQEN:  rdata_out <= irqen_q;
                    `SWC_REG_WAKE:   rdata_out <= {5'h00, cause_q};
                    default:         rdata_out <= 8'h00;
                endcase
            end
        end
    end
    // Counter value kept internal; only timeouts matter outside
    wire unused_cnt = ^wdt_count;
endmodule // swc_ctrl

// file: test/swc_core_model.sv
`timescale 1ns/1ps
module swc_core_model (
    // Clock and reset
    input  logic       clk_in,
    input  logic       rst_in,
    // Commands from the bench
    input  logic       sleep_req_in,
    input  logic       clr_req_in,
    // From the controller
    input  logic       core_clk_en_in,
    input  logic       resume_in,
    // To the controller
    output logic       sleep_exec_out,
    output logic       clrwdt_out,
    output logic [7:0] resume_cnt_out
);
    // A gated core issues nothing, so requests made in sleep are lost
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sleep_exec_out <= 1'b0;
            clrwdt_out <= 1'b0;
            resume_cnt_out <= 8'h00;
        end else begin
            sleep_exec_out <= sleep_req_in && core_clk_en_in && !sleep_exec_out;
            clrwdt_out <= clr_req_in && core_clk_en_in && !clrwdt_out;
            // Word after sleep is a no-op here, so counting is all it does
            if (resume_in) begin
                resume_cnt_out <= resume_cnt_out + 8'h01;
            end
        end
    end
endmodule // swc_core_model

// file: test/swc_ctrl_checker.sv
`timescale 1ns/1ps
module swc_ctrl_checker #(
    parameter NPORT = 8
) (
    input logic             clk_in,
    input logic             rst_in,
    input logic             sleep_exec_in,
    input logic             master_clear_pin_pin_in,
    input logic             bor_in,
    input logic             por_in,
    input logic             core_clk_en_out,
    input logic             prefetch_out,
    input logic             resume_out,
    input logic             isr_call_out,
    input logic             dev_reset_out,
    input logic             lfosc_en_out,
    input logic             sense_osc_en_out,
    input logic [NPORT-1:0] port_drv_out,
    input logic [NPORT-1:0] port_oe_out,
    input logic             asleep_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sleep_entry_a: assert property (
        (!por_in && !bor_in && !master_clear_pin_pin_in)[*5] ##0 (sleep_exec_in && !asleep_out)
        |=> asleep_out) else $error("sleep entry missed");
    prefetch_a: assert property (
        $rose(asleep_out) |-> prefetch_out) else $error("no prefetch on entry");
    clk_gate_a: assert property (
        asleep_out |-> !core_clk_en_out) else $error("core clock on in sleep");
    port_hold_a: assert property (
        asleep_out && $past(asleep_out) |-> $stable(port_drv_out) && $stable(port_oe_out))
        else $error("port state moved in sleep");
    wake_clk_a: assert property (
        $fell(asleep_out) |-> core_clk_en_out) else $error("clock off after wake");
    resume_a: assert property (
        $fell(asleep_out) && !dev_reset_out |=> resume_out) else $error("no resume");
    isr_pair_a: assert property (
        isr_call_out |-> resume_out) else $error("handler call without resume");
    osc_alive_a: assert property (
        asleep_out |-> lfosc_en_out && sense_osc_en_out) else $error("osc stopped");
    por_wake_a: assert property (
        $rose(por_in) |-> ##[2:6] dev_reset_out) else $error("power-on ignored");
endmodule // swc_ctrl_checker

bind swc_ctrl swc_ctrl_checker #(.NPORT(NPORT)) i_swc_ctrl_checker (
    .clk_in, .rst_in, .sleep_exec_in, .master_clear_pin_pin_in, .bor_in, .por_in, .core_clk_en_out,
    .prefetch_out, .resume_out, .isr_call_out, .dev_reset_out, .lfosc_en_out,
    .sense_osc_en_out, .port_drv_out, .port_oe_out, .asleep_out);

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, irq = 8'h00, pdrv = 8'h00, poe = 8'h00;
    logic       wr = 1'b0, rd = 1'b0, slp_req = 1'b0, clr_req = 1'b0;
    logic       mcp = 1'b0, brown = 1'b0, por = 1'b0;
    wire  [7:0] rdata, port_drv, port_oe, res_cnt;
    wire        clk_en, resume, isr, dev_rst, dog_rst, lf, t1, adc, sen, asleep, slp, clr;
    int         fails = 0, total_checks = 0, n;
    always #5 clk_in = ~clk_in;
    swc_ctrl #(.WDT_LIMIT(16'h0010)) i_swc_ctrl (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sleep_exec_in(slp), .clrwdt_in(clr),
        .core_clk_en_out(clk_en), .prefetch_out(), .resume_out(resume), .isr_call_out(isr),
        .master_clear_pin_pin_in(mcp), .bor_in(brown), .por_in(por), .dev_reset_out(dev_rst),
        .wdt_reset_out(dog_rst), .irq_flag_in(irq), .lfosc_en_out(lf), .t1_clk_en_out(t1),
        .adc_clk_en_out(adc), .sense_osc_en_out(sen), .port_drv_in(pdrv), .port_oe_in(poe),
        .port_drv_out(port_drv), .port_oe_out(port_oe), .asleep_out(asleep));
    swc_core_model i_swc_core_model (
        .clk_in(clk_in), .rst_in(rst_in), .sleep_req_in(slp_req), .clr_req_in(clr_req),
        .core_clk_en_in(clk_en), .resume_in(resume), .sleep_exec_out(slp),
        .clrwdt_out(clr), .resume_cnt_out(res_cnt));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk("rdata", rdata, e);
    endtask
    // Core command: 1 sleeps, 0 clears the dog; lost while the core clock is off
    task pulse(input logic s);
        @(posedge clk_in);
        slp_req <= s;
        clr_req <= !s;
        @(posedge clk_in);
        slp_req <= 1'b0;
        clr_req <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task wait_sig(input int sel, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_in);
            #1 cnt++;
        end while (!(sel == 0 ? resume : sel == 1 ? dev_rst : dog_rst) && cnt < 60);
        if (cnt >= 60) chk("wait", 8'h00, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_irq(input logic global_interrupt_enable);
        wr_reg(4'h2, 8'h01);
        wr_reg(4'h0, {5'h00, global_interrupt_enable, 2'h0});
        pdrv <= 8'hA5;
        poe <= 8'h0F;
        pulse(1'b1);
        rd_reg(4'h1, 8'h06);
        chk("clk_en", 8'(clk_en), 8'h00);
        chk("sleep_clks", {6'h00, adc, t1}, 8'h00);
        pdrv <= 8'h5A;
        poe <= 8'hF0;
        irq <= 8'h02;
        repeat (6) @(posedge clk_in);
        #1 chk("port_drv", port_drv, 8'hA5);
        chk("port_oe", port_oe, 8'h0F);
        chk("masked", 8'(asleep), 8'h01);
        irq <= 8'h03;
        wait_sig(0, n);
        chk("isr", 8'(isr), 8'(global_interrupt_enable));
        rd_reg(4'h3, 8'h02);
        irq <= 8'h00;
        pulse(1'b0);
        rd_reg(4'h1, 8'h03);
    endtask
    task t_dog;
        wr_reg(4'h0, 8'h63);
        repeat (4) @(posedge clk_in);
        pulse(1'b1);
        chk("adc_clk", 8'(adc), 8'h01);
        chk("t1_clk", 8'(t1), 8'h01);
        chk("osc", {6'h00, lf, sen}, 8'h03);
        wait_sig(0, n);
        chk("sleep_len", 8'(n >= 10), 8'h01);
        rd_reg(4'h3, 8'h01);
        rd_reg(4'h1, 8'h00);
        wait_sig(2, n);
        chk("wake_clr", 8'(n >= 8), 8'h01);
        wr_reg(4'h0, 8'h00);
        pulse(1'b0);
        rd_reg(4'h1, 8'h03);
    endtask
    task t_rst;
        pulse(1'b1);
        mcp <= 1'b1;
        repeat (10) @(posedge clk_in);
        #1 chk("pin_off", 8'(asleep), 8'h01);
        mcp <= 1'b0;
        // Let the pin synchroniser drain before the pin reset gets enabled
        repeat (6) @(posedge clk_in);
        // A request in sleep is dropped by the gated core, so asleep stays set
        for (int k = 0; k < 3; k++) begin
            wr_reg(4'h0, k == 0 ? 8'h08 : k == 1 ? 8'h10 : 8'h00);
            pulse(1'b1);
            {mcp, brown, por} <= 3'b100 >> k;
            wait_sig(1, n);
            chk("asleep", 8'(asleep), 8'h00);
            chk("clk_en", 8'(clk_en), 8'h01);
            {mcp, brown, por} <= 3'b000;
            repeat (8) @(posedge clk_in);
            #1 chk("resumes", res_cnt, 8'h03);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        rd_reg(4'h1, 8'h03);
        rd_reg(4'h0, 8'h00);
        rd_reg(4'hF, 8'h00);
        wr_reg(4'h1, 8'hFF);
        rd_reg(4'h1, 8'h03);
        t_irq(1'b0);
        t_irq(1'b1);
        t_dog;
        t_rst;
        stop_test;
    end
    // About twenty-five times the expected run
    initial begin
        #50000;
        fails++;
        stop_test;
    end
endmodule // tb
